//--- hdl/fspm_params.svh
// Constants for the fault status and protection monitor.
`ifndef FSPM_PARAMS_SVH
`define FSPM_PARAMS_SVH
`define FSPM_BIT_BUSY     3'd0
`define FSPM_BIT_OFF      3'd1
`define FSPM_BIT_OUT      3'd2
`define FSPM_BIT_CUR      3'd3
`define FSPM_BIT_IN       3'd4
`define FSPM_BIT_TEMP     3'd5
`define FSPM_BIT_LOGIC    3'd6
`define FSPM_STATUS_RST   8'h00
`define FSPM_LATCH_MASK   8'h7C
`define FSPM_DEGLITCH_NS  1000
`define FSPM_DEGLITCH_CYC ((`FSPM_DEGLITCH_NS + 7) / 8)
`define FSPM_BOOT_FORCED_PWM_CYC 8'h08
`define FSPM_BOOT_RFSH_CYC 8'h04
`endif

//--- hdl/fspm_pkg.sv
// Types shared by the fault status and protection monitor.
package fspm_pkg;
	typedef enum logic [3:0] {
		FSPM_OFF   = 4'b0001,
		FSPM_SOFT  = 4'b0010,
		FSPM_RUN   = 4'b0100,
		FSPM_HICUP = 4'b1000
	} fspm_state_t;
endpackage

//--- hdl/fspm_deglitch.sv
// Deglitch filter: output follows input once it has been stable for a count.
`timescale 1ns/1ns
`include "fspm_params.svh"
module fspm_deglitch (
	input  wire logic clk,
	input  wire logic resetn,
	input  wire logic raw,
	output logic      clean
);
	localparam int CYC = `FSPM_DEGLITCH_CYC;
	logic [7:0] cnt;
	wire        differ = raw != clean;
	wire        done   = cnt == 8'(CYC - 1);

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cnt   <= 8'h00;
			clean <= 1'b0;
		end else if (!differ) begin
			cnt <= 8'h00;
		end else if (done) begin
			cnt   <= 8'h00;
			clean <= raw;
		end else begin
			cnt <= cnt + 8'h01;
		end
	end

	// A change appears exactly CYC cycles after a steady new level.
	property p_count;
		@(posedge clk) disable iff (!resetn) cnt < 8'(CYC);
	endproperty
	a_count: assert property (p_count) else $error("deglitch counter overran");

	property p_follow;
		@(posedge clk) disable iff (!resetn)
		$changed(clean) |-> $past(raw) == clean && $past(done);
	endproperty
	a_follow: assert property (p_follow) else $error("deglitch output moved early");
endmodule

//--- hdl/fspm_bootmon.sv
// Bootstrap undervoltage counter: stops or refreshes per switching cycle.
`timescale 1ns/1ns
`include "fspm_params.svh"
module fspm_bootmon (
	input  wire logic clk,
	input  wire logic resetn,
	input  wire logic sw_cycle,
	input  wire logic bootstrap_undervoltage,
	input  wire logic forced_pwm,
	input  wire logic running,
	output logic      boot_refresh,
	output logic      boot_stop
);
	logic [7:0] cnt;
	wire  [7:0] limit = forced_pwm ? `FSPM_BOOT_FORCED_PWM_CYC : `FSPM_BOOT_RFSH_CYC;
	wire        hit   = sw_cycle && cnt == limit - 8'h01;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cnt       <= 8'h00;
			boot_stop <= 1'b0;
		end else if (!bootstrap_undervoltage || !running) begin
			cnt       <= 8'h00;
			boot_stop <= 1'b0;
		end else if (hit) begin
			boot_stop <= 1'b1;
		end else if (sw_cycle) begin
			cnt <= cnt + 8'h01;
		end
	end
	// In power save mode undervoltage forces refresh switching.
	assign boot_refresh = bootstrap_undervoltage && running && !forced_pwm && !boot_stop;

	property p_stop_cause;
		@(posedge clk) disable iff (!resetn)
		$rose(boot_stop) |-> $past(bootstrap_undervoltage) && $past(sw_cycle);
	endproperty
	a_stop_cause: assert property (p_stop_cause)
		else $error("bootstrap stop without undervoltage cycle");

	property p_stop_hold;
		@(posedge clk) disable iff (!resetn)
		boot_stop && bootstrap_undervoltage && running |=> boot_stop;
	endproperty
	a_stop_hold: assert property (p_stop_hold) else $error("bootstrap stop dropped");
endmodule

//--- hdl/fspm_monitor.sv
// Fault status byte, fault pin and protective reactions of the converter.
`timescale 1ns/1ns
`include "fspm_params.svh"
module fspm_monitor (
	input  wire logic       clk,
	input  wire logic       resetn,
	input  wire logic       startup_done,
	input  wire logic       reg_busy,
	input  wire logic       system_enable,
	input  wire logic       output_below_pg,
	input  wire logic       overvoltage_level_one,
	input  wire logic       overvoltage_level_two,
	input  wire logic       ov_level_two_enable,
	input  wire logic       peak_current_trip,
	input  wire logic       input_voltage_detect,
	input  wire logic       uvlo_sense_low,
	input  wire logic       thermal_shutdown,
	input  wire logic       thermal_warning,
	input  wire logic       checksum_done,
	input  wire logic       checksum_match,
	input  wire logic       avg_limit_enable,
	input  wire logic       avg_limit_reached,
	input  wire logic       micro_sleep,
	input  wire logic       internal_feedback,
	input  wire logic       softstart_done,
	input  wire logic       input_overvoltage_protect,
	input  wire logic       input_protect_enable,
	input  wire logic       input_regulation_enable,
	input  wire logic       forced_pwm_request,
	input  wire logic       mode_pin_low,
	input  wire logic       hiccup_enable,
	input  wire logic       bootstrap_undervoltage,
	input  wire logic       sw_cycle,
	input  wire logic       interrupt_mode_select,
	input  wire logic       clear_faults_access,
	input  wire logic       status_write,
	input  wire logic [7:0] status_wdata,
	output logic      [7:0] status_byte,
	output logic            avg_current_limit_flag,
	output logic      [7:0] power_delivery_status,
	output logic            fault_interrupt_pin_o,
	output logic            fault_interrupt_pin_oe,
	output logic            converter_run,
	output logic            switch_nodes_hiz,
	output logic            forced_pwm,
	output logic            forward_only,
	output logic            input_voltage_regulation,
	output logic            boot_refresh,
	output logic            power_good,
	output logic            converter_off_state
);
	localparam int NF = 8;
	fspm_pkg::fspm_state_t state;
	fspm_pkg::fspm_state_t next_state;
	logic [7:0] latched;
	logic [7:0] clean_q;
	logic       pin_toggle;
	logic       crc_bad;
	logic       boot_stop;
	logic       overvoltage_level_two_hold;
	logic [NF-1:0] raw;
	logic [NF-1:0] clean;

	function automatic logic [7:0] place(input logic [2:0] pos, input logic v);
		place = {7'h00, v} << pos;
	endfunction

	wire overvoltage_level_one_ok = overvoltage_level_one && !micro_sleep && softstart_done
		&& !internal_feedback;
	wire overvoltage_level_two_ok = overvoltage_level_two && ov_level_two_enable;

	// Raw event vector, index 7 feeds the average current flag.
	assign raw = {avg_limit_enable && avg_limit_reached,
		crc_bad,
		thermal_shutdown || thermal_warning,
		input_voltage_detect || uvlo_sense_low,
		peak_current_trip,
		overvoltage_level_one_ok || overvoltage_level_two_ok,
		output_below_pg || !system_enable,
		reg_busy};

	genvar gi;
	generate
		for (gi = 0; gi < NF; gi++) begin : g_dg
			fspm_deglitch u_dg (
				.clk    (clk),
				.resetn (resetn),
				.raw    (raw[gi]),
				.clean  (clean[gi])
			);
		end
	endgenerate

	wire [7:0] set_mask = place(`FSPM_BIT_OUT, clean[2]) | place(`FSPM_BIT_CUR, clean[3])
		| place(`FSPM_BIT_IN, clean[4]) | place(`FSPM_BIT_TEMP, clean[5])
		| place(`FSPM_BIT_LOGIC, clean[6]);
	wire [7:0] clr_mask = clear_faults_access ? 8'hFF
		: (status_write ? status_wdata : 8'h00);
	wire [7:0] next_latched = (latched & ~clr_mask | set_mask) & `FSPM_LATCH_MASK;
	wire [7:0] live = place(`FSPM_BIT_BUSY, clean[0] && startup_done)
		| place(`FSPM_BIT_OFF, clean[1] && startup_done);
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			latched <= `FSPM_STATUS_RST;
		end else begin
			latched <= next_latched;
		end
	end

	assign status_byte = (latched | live) & 8'h7F;
	assign avg_current_limit_flag = clean[7];
	assign power_delivery_status  = {7'h00, clean[7]};

	// Checksum verdict is caught once it is known and held until reset.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			crc_bad <= 1'b0;
		end else if (checksum_done && !checksum_match) begin
			crc_bad <= 1'b1;
		end
	end

	// Interrupt mode toggles the pin level on any change of the deglitched event vector.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			clean_q    <= 8'h00;
			pin_toggle <= 1'b0;
		end else begin
			clean_q <= clean;
			if (clean != clean_q) begin
				pin_toggle <= !pin_toggle;
			end
		end
	end

	wire fault_any = |(status_byte & `FSPM_LATCH_MASK);
	assign fault_interrupt_pin_o  = 1'b0;
	assign fault_interrupt_pin_oe = interrupt_mode_select ? pin_toggle : fault_any;

	// Main sequencing of converter on, soft-start, run and hiccup.
	wire stop_now = thermal_shutdown || crc_bad || !system_enable || boot_stop;
	always_comb begin
		next_state = state;
		case (state)
			fspm_pkg::FSPM_OFF:
				if (!stop_now) begin
					next_state = fspm_pkg::FSPM_SOFT;
				end
			fspm_pkg::FSPM_SOFT:
				if (stop_now) begin
					next_state = fspm_pkg::FSPM_OFF;
				end else if (softstart_done) begin
					next_state = fspm_pkg::FSPM_RUN;
				end
			fspm_pkg::FSPM_RUN:
				if (stop_now) begin
					next_state = fspm_pkg::FSPM_OFF;
				end else if (hiccup_enable && peak_current_trip) begin
					next_state = fspm_pkg::FSPM_HICUP;
				end
			fspm_pkg::FSPM_HICUP:
				next_state = fspm_pkg::FSPM_OFF;
			default:
				next_state = fspm_pkg::FSPM_OFF;
		endcase
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state <= fspm_pkg::FSPM_OFF;
		end else begin
			state <= next_state;
		end
	end

	// Switch nodes open one cycle after level two rises above its threshold with ov_level_two_enable set, and close one cycle after that ends.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			overvoltage_level_two_hold <= 1'b0;
		end else begin
			overvoltage_level_two_hold <= overvoltage_level_two_ok;
		end
	end

	wire running = state == fspm_pkg::FSPM_SOFT || state == fspm_pkg::FSPM_RUN;
	assign converter_off_state = state == fspm_pkg::FSPM_OFF;
	assign converter_run       = running && !overvoltage_level_two_hold;
	assign switch_nodes_hiz    = !converter_run;
	assign forward_only        = input_protect_enable && input_overvoltage_protect;
	assign forced_pwm          = forced_pwm_request && !mode_pin_low && !forward_only;
	assign input_voltage_regulation = input_protect_enable && input_regulation_enable
		&& forced_pwm_request && !mode_pin_low && running;
	assign power_good = state == fspm_pkg::FSPM_RUN && !output_below_pg;

	fspm_bootmon u_boot (
		.clk                    (clk),
		.resetn                 (resetn),
		.sw_cycle               (sw_cycle),
		.bootstrap_undervoltage (bootstrap_undervoltage),
		.forced_pwm             (forced_pwm),
		.running                (running),
		.boot_refresh           (boot_refresh),
		.boot_stop              (boot_stop)
	);

	property p_clear;
		@(posedge clk) disable iff (!resetn)
		clear_faults_access && set_mask == 8'h00 |=> (latched == 8'h00);
	endproperty
	a_clear: assert property (p_clear) else $error("clear left a fault latched");

	property p_latch;
		@(posedge clk) disable iff (!resetn)
		clean[3] |=> status_byte[`FSPM_BIT_CUR];
	endproperty
	a_latch: assert property (p_latch) else $error("overcurrent not latched");

	property p_hold;
		@(posedge clk) disable iff (!resetn)
		latched[`FSPM_BIT_TEMP] && !clear_faults_access && !status_write
			|=> latched[`FSPM_BIT_TEMP];
	endproperty
	a_hold: assert property (p_hold) else $error("temperature fault dropped");

	property p_unused;
		@(posedge clk) disable iff (!resetn) !status_byte[7];
	endproperty
	a_unused: assert property (p_unused) else $error("unused status bit set");

	property p_pin;
		@(posedge clk) disable iff (!resetn)
		!interrupt_mode_select |-> fault_interrupt_pin_oe == fault_any;
	endproperty
	a_pin: assert property (p_pin) else $error("fault pin does not follow status");

	property p_crc;
		@(posedge clk) disable iff (!resetn)
		crc_bad && converter_off_state |=> converter_off_state;
	endproperty
	a_crc: assert property (p_crc) else $error("left off state despite checksum");

	property p_tsd;
		@(posedge clk) disable iff (!resetn)
		thermal_shutdown ##1 thermal_shutdown |-> converter_off_state;
	endproperty
	a_tsd: assert property (p_tsd) else $error("running during thermal shutdown");

	property p_pg;
		@(posedge clk) disable iff (!resetn) !softstart_done |-> !power_good;
	endproperty
	a_pg: assert property (p_pg) else $error("power good before soft-start end");
endmodule

//--- verif/fspm_host_model.sv
// Host model that issues clear and write-one-to-clear pulses and sets the pin mode.
`timescale 1ns/1ns
module fspm_host_model (
	input  wire logic       clk,
	input  wire logic       resetn,
	input  wire logic       converter_off_state,
	input  wire logic       req_clear,
	input  wire logic       req_write,
	input  wire logic [7:0] req_mask,
	input  wire logic       req_mode,
	output logic            clear_faults_access,
	output logic            status_write,
	output logic      [7:0] status_wdata,
	output logic            interrupt_mode_select
);
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			clear_faults_access <= 1'b0;
			status_write <= 1'b0;
			status_wdata <= 8'h00;
			interrupt_mode_select <= 1'b0;
		end else begin
			clear_faults_access <= req_clear;
			status_write <= req_write;
			status_wdata <= req_write ? req_mask : ~status_wdata;
			// The mode only moves while the converter is off, never mid-run.
			if (converter_off_state) begin
				interrupt_mode_select <= req_mode;
			end
		end
	end
endmodule

//--- verif/test_fspm_monitor.sv
// Self-checking bench for the fault status byte, fault pin and checksum gate.
`timescale 1ns/1ns
module test_fspm_monitor;
	logic clk, resetn, startup_done, reg_busy, system_enable, output_below_pg;
	logic overvoltage_level_one, overvoltage_level_two, ov_level_two_enable;
	logic peak_current_trip, input_voltage_detect, uvlo_sense_low, thermal_shutdown;
	logic thermal_warning, checksum_done, checksum_match, avg_limit_enable;
	logic avg_limit_reached, micro_sleep, internal_feedback, softstart_done;
	logic input_overvoltage_protect, input_protect_enable, input_regulation_enable;
	logic forced_pwm_request, mode_pin_low, hiccup_enable, bootstrap_undervoltage;
	logic sw_cycle, interrupt_mode_select, clear_faults_access, status_write;
	logic [7:0] status_wdata, status_byte, power_delivery_status, req_mask;
	logic avg_current_limit_flag, fault_interrupt_pin_o, fault_interrupt_pin_oe;
	logic converter_run, switch_nodes_hiz, forced_pwm, forward_only;
	logic input_voltage_regulation, boot_refresh, power_good, converter_off_state;
	logic req_clear, req_write, req_mode, o;
	int errors, tests_run;
	localparam logic [7:0] BITM [4] = '{8'h04, 8'h10, 8'h20, 8'h08};

	fspm_monitor dut (.*);
	fspm_host_model host (.*);

	always #4 clk = ~clk;

	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("ERROR t=%0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic set_src(input int i, input logic v);
		case (i)
			0: overvoltage_level_two = v;
			1: uvlo_sense_low = v;
			2: thermal_warning = v;
			default: peak_current_trip = v;
		endcase
	endtask

	task automatic complete_run;
		$display("errors=%0d tests_run=%0d", errors, tests_run);
		if (errors == 0 && tests_run > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	initial begin
		{clk, resetn, reg_busy, system_enable, output_below_pg} = '0;
		{overvoltage_level_one, overvoltage_level_two, peak_current_trip} = '0;
		{input_voltage_detect, uvlo_sense_low, thermal_shutdown, thermal_warning} = '0;
		{avg_limit_enable, avg_limit_reached, micro_sleep, internal_feedback} = '0;
		{input_overvoltage_protect, input_protect_enable, input_regulation_enable} = '0;
		{forced_pwm_request, mode_pin_low, hiccup_enable, bootstrap_undervoltage} = '0;
		{sw_cycle, req_clear, req_write, req_mode, req_mask} = '0;
		{startup_done, ov_level_two_enable, checksum_done, checksum_match} = '1;
		softstart_done = 1'b1;
		errors = 0;
		tests_run = 0;
		step(4);
		chk(status_byte, 8'h00);
		chk({6'h00, converter_off_state, fault_interrupt_pin_oe}, 8'h02);
		resetn = 1'b1;
		step(130);
		chk(status_byte, 8'h02);
		$display("reset test done");
		for (int i = 0; i < 4; i++) begin
			set_src(i, 1'b1);
			step(120);
			chk(status_byte & BITM[i], 8'h00);
			step(10);
			chk(status_byte & BITM[i], BITM[i]);
			chk({7'h00, fault_interrupt_pin_oe}, 8'h01);
			set_src(i, 1'b0);
			step(130);
			chk(status_byte & 8'hFC, BITM[i]);
			// Clear the latched bit: write-one-to-clear for the first two sources, clear access for the rest.
			req_write = 1'b1;
			req_mask = (i < 2) ? BITM[i] : 8'h00;
			req_clear = (i >= 2);
			step(1);
			{req_write, req_clear} = 2'b00;
			step(3);
			chk(status_byte & 8'hFC, 8'h00);
			chk({7'h00, fault_interrupt_pin_oe}, 8'h00);
			chk(status_byte & 8'h80, 8'h00);
			$display("latch test %0d done", i);
		end
		avg_limit_reached = 1'b1;
		step(130);
		chk({7'h00, avg_current_limit_flag}, 8'h00);
		avg_limit_enable = 1'b1;
		step(130);
		chk(power_delivery_status, {7'h00, avg_current_limit_flag});
		chk(power_delivery_status, 8'h01);
		$display("average limit test done");
		req_mode = 1'b1;
		step(3);
		o = fault_interrupt_pin_oe;
		reg_busy = 1'b1;
		step(130);
		chk(status_byte & 8'h01, 8'h01);
		chk({7'h00, fault_interrupt_pin_oe}, {7'h00, ~o});
		$display("toggle test done");
		system_enable = 1'b1;
		step(3);
		chk({6'h00, converter_run, switch_nodes_hiz}, 8'h02);
		chk({7'h00, power_good}, 8'h01);
		chk({7'h00, fault_interrupt_pin_o}, 8'h00);
		{forced_pwm_request, input_protect_enable, input_regulation_enable} = 3'b111;
		step(1);
		chk({5'h00, forced_pwm, forward_only, input_voltage_regulation}, 8'h05);
		input_overvoltage_protect = 1'b1;
		step(1);
		chk({5'h00, forced_pwm, forward_only, input_voltage_regulation}, 8'h03);
		mode_pin_low = 1'b1;
		step(1);
		chk({5'h00, forced_pwm, forward_only, input_voltage_regulation}, 8'h02);
		{forced_pwm_request, input_protect_enable, input_regulation_enable} = 3'b000;
		{input_overvoltage_protect, mode_pin_low} = 2'b00;
		bootstrap_undervoltage = 1'b1;
		step(1);
		chk({7'h00, boot_refresh}, 8'h01);
		sw_cycle = 1'b1;
		step(4);
		sw_cycle = 1'b0;
		step(1);
		chk({7'h00, converter_off_state}, 8'h01);
		bootstrap_undervoltage = 1'b0;
		step(4);
		chk({7'h00, converter_run}, 8'h01);
		{hiccup_enable, peak_current_trip} = 2'b11;
		step(2);
		chk({7'h00, converter_off_state}, 8'h01);
		{hiccup_enable, peak_current_trip} = 2'b00;
		step(3);
		chk({7'h00, converter_run}, 8'h01);
		thermal_shutdown = 1'b1;
		step(2);
		chk({7'h00, converter_off_state}, 8'h01);
		step(130);
		chk(status_byte & 8'h20, 8'h20);
		thermal_shutdown = 1'b0;
		step(3);
		chk({7'h00, converter_run}, 8'h01);
		$display("protection test done");
		resetn = 1'b0;
		step(4);
		{reg_busy, req_mode, checksum_match} = '0;
		resetn = 1'b1;
		system_enable = 1'b1;
		step(300);
		chk({7'h00, converter_off_state}, 8'h01);
		chk(status_byte & 8'h40, 8'h40);
		$display("checksum test done");
		complete_run();
	end

	initial begin
		#100000;
		errors++;
		complete_run();
	end
endmodule
